//--- core/dtt_ctrl.sv
// Termination timing control of a synchronous DRAM
// Assumes pin and commands registered on ref_clk_i rising edges
// Function
// [R1] Synchronous timing while loop is locked
// [R2] Nominal on after write-latency sum minus two/three
// [R3] Nominal off after same direct latency
// [R4] Read turns termination off after read latency; code turns it off at read latency minus two/three
// [R5] Fixed chop: park back after off plus 4/5
// [R6] Full or on-the-fly: park back plus 6/7
// [R7] Controller holds pin high minimum chop/full time
// [R8] Hold counted from first high or write
// [R9] Controller lengthens hold with CRC or long preamble
// [R10] No termination while driving read data
// [R11] Dynamic termination when A9 or A10 set
// [R12] Strengths from mode registers one, two, five
// [R13] Nominal by pin outside writes, park otherwise
// [R14] Write strength after write latency minus two/three
// [R15] Short preamble no CRC: release plus 4/6
// [R16] CRC or long preamble: longer release offsets
// [R17] No dynamic termination with loop off
// [R18] Controller writes zero field to disable dynamic
// [R19] Loop off: nominal follows pin without latency
// [R20] Loop off: park to nominal and back on samples
// [R21] Priority: disabled, write, nominal, park
// [R22] After write release: nominal if pin, else park
`include "dtt_defs.svh"
module dtt_ctrl #(
  parameter int HIST_DEPTH = 128
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic die_termination_pin_i,
  input wire logic cmd_write_i,
  input wire logic cmd_read_i,
  input wire logic cmd_chop_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output dtt_pkg::dtt_kind_t rtt_kind_o,
  output logic [2:0] rtt_code_o
);
  logic [15:0] mode_reg_one;
  logic [15:0] mode_reg_two;
  logic [15:0] mode_reg_five;
  logic [15:0] lat_cfg;
  logic [15:0] mode_cfg;
  logic [15:0] next_mode_reg_one;
  logic [15:0] next_mode_reg_two;
  logic [15:0] next_mode_reg_five;
  logic [15:0] next_lat_cfg;
  logic [15:0] next_mode_cfg;
  logic [15:0] next_reg_rdata;
  dtt_pkg::dtt_kind_t next_rtt_kind;
  logic [2:0] next_rtt_code;

  logic [2:0] nominal_termination;
  logic [2:0] write_code;
  logic [2:0] park_code;
  logic dyn_en;
  logic dll_on;
  logic pre2;
  logic crc_on;
  dtt_pkg::dtt_burst_t burst_mode;
  logic chop_fixed;
  logic chop_eff;
  logic [7:0] sub;
  logic [7:0] write_latency;
  logic [7:0] read_sum;
  logic [6:0] direct_term_on_delay;
  logic [6:0] read_term_off_delay;
  logic [6:0] read_park_restore;
  logic [6:0] write_strength_on_delay;
  logic [6:0] write_strength_off_chop;
  logic [6:0] write_strength_off_full;
  logic [6:0] wc_add;
  logic [6:0] wf_add;
  logic nom_req;
  logic rd_win;
  logic wr_win;

  dtt_hist_if #(.DEPTH(HIST_DEPTH)) hif[4] ();

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_line
      dtt_hist #(.DEPTH(HIST_DEPTH)) u_line (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .lp(hif[g])
      );
    end
  endgenerate

  // Sum less offset, never below one cycle
  function automatic logic [6:0] dtt_lat(input logic [7:0] sum,
                                         input logic [7:0] off);
    logic [7:0] d;
    d = (sum > off) ? sum - off : `DTT_MIN_LAT;
    return d[6:0];
  endfunction

  // Any event lo..hi cycles back in a history line
  function automatic logic dtt_win(input logic [HIST_DEPTH-1:0] h,
                                   input logic [6:0] lo,
                                   input logic [6:0] hi);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < HIST_DEPTH; i++) begin
      if (i >= int'(lo) && i <= int'(hi)) begin
        hit = hit | h[i];
      end
    end
    return hit;
  endfunction

  assign nominal_termination = mode_reg_one[`DTT_NOM_HI:`DTT_NOM_LO]; // R12
  assign write_code = mode_reg_two[`DTT_WR_HI:`DTT_WR_LO]; // R12
  assign park_code = mode_reg_five[`DTT_PARK_HI:`DTT_PARK_LO]; // R12
  assign dyn_en = mode_reg_two[`DTT_DYN_A9] | mode_reg_two[`DTT_DYN_A10]; // R11
  assign dll_on = mode_cfg[`DTT_DLL];
  assign pre2 = mode_cfg[`DTT_PRE2];
  assign crc_on = mode_cfg[`DTT_CRC];
  assign burst_mode =
    dtt_pkg::dtt_burst_t'(mode_cfg[`DTT_BURST_HI:`DTT_BURST_LO]);
  assign chop_fixed = (burst_mode == dtt_pkg::DTT_BC4_FIXED);
  assign chop_eff = chop_fixed |
                    ((burst_mode != dtt_pkg::DTT_BL8_FIXED) & cmd_chop_i);

  // Pin, read, short write and full write history lines
  assign hif[0].sample = die_termination_pin_i;
  assign hif[1].sample = cmd_read_i;
  assign hif[2].sample = cmd_write_i & chop_eff;
  assign hif[3].sample = cmd_write_i & ~chop_eff;

  always_comb begin
    sub = pre2 ? `DTT_SUB_PRE2 : `DTT_SUB_PRE1;
    write_latency = {3'h0, lat_cfg[`DTT_CWL_HI:`DTT_CWL_LO]} +
                    {3'h0, lat_cfg[`DTT_AL_HI:`DTT_AL_LO]} +
                    {4'h0, lat_cfg[`DTT_PL_HI:`DTT_PL_LO]};
    read_sum = {3'h0, mode_cfg[`DTT_CL_HI:`DTT_CL_LO]} +
               {3'h0, lat_cfg[`DTT_AL_HI:`DTT_AL_LO]} +
               {4'h0, lat_cfg[`DTT_PL_HI:`DTT_PL_LO]};
    direct_term_on_delay = dtt_lat(write_latency, sub); // R2 R3
    read_term_off_delay = dtt_lat(read_sum, sub); // R4
    if (chop_fixed) begin
      read_park_restore = read_term_off_delay +
        (pre2 ? `DTT_RD_CHOP_PRE2 : `DTT_RD_CHOP_PRE1); // R5
    end else begin
      read_park_restore = read_term_off_delay +
        (pre2 ? `DTT_RD_FULL_PRE2 : `DTT_RD_FULL_PRE1); // R6
    end
    write_strength_on_delay = dtt_lat(write_latency, sub); // R14
    unique case ({pre2, crc_on})
      2'h0: begin
        wc_add = `DTT_WC_PRE1; // R15
        wf_add = `DTT_WF_PRE1; // R15
      end
      2'h1: begin
        wc_add = `DTT_WC_PRE1_CRC; // R16
        wf_add = `DTT_WF_PRE1_CRC; // R16
      end
      2'h2: begin
        wc_add = `DTT_WC_PRE2; // R16
        wf_add = `DTT_WF_PRE2; // R16
      end
      2'h3: begin
        wc_add = `DTT_WC_PRE2_CRC; // R16
        wf_add = `DTT_WF_PRE2_CRC; // R16
      end
    endcase
    write_strength_off_chop = write_strength_on_delay + wc_add;
    write_strength_off_full = write_strength_on_delay + wf_add;
  end

  // Requests seen by the next edge; index L-1 lands the change at L
  always_comb begin
    if (dll_on) begin
      // R1
      nom_req = (nominal_termination != 3'h0) &
                hif[0].hist[direct_term_on_delay - 7'h01]; // R2 R3 R13
      rd_win = dtt_win(hif[1].hist, read_term_off_delay - 7'h01,
                       read_park_restore - 7'h02); // R4 R10
      wr_win = dyn_en &
               (dtt_win(hif[2].hist, write_strength_on_delay - 7'h01,
                        write_strength_off_chop - 7'h02) |
                dtt_win(hif[3].hist, write_strength_on_delay - 7'h01,
                        write_strength_off_full - 7'h02)); // R14
    end else begin
      // Read windows need the locked loop's latencies
      nom_req = (nominal_termination != 3'h0) & hif[0].hist[0]; // R19 R20
      rd_win = 1'b0;
      wr_win = 1'b0; // R17
    end
  end

  // Strength resolution; release of write falls through to pin state
  always_comb begin
    if (rd_win) begin
      next_rtt_kind = dtt_pkg::DTT_HIZ; // R21 R10
    end else if (wr_win) begin
      next_rtt_kind = dtt_pkg::DTT_WRITE; // R21
    end else if (nom_req) begin
      next_rtt_kind = dtt_pkg::DTT_NOM; // R21 R22
    end else if (park_code != 3'h0) begin
      next_rtt_kind = dtt_pkg::DTT_PARK; // R13 R22
    end else begin
      next_rtt_kind = dtt_pkg::DTT_HIZ;
    end
    unique case (next_rtt_kind)
      dtt_pkg::DTT_HIZ: next_rtt_code = 3'h0;
      dtt_pkg::DTT_PARK: next_rtt_code = park_code;
      dtt_pkg::DTT_NOM: next_rtt_code = nominal_termination;
      dtt_pkg::DTT_WRITE: next_rtt_code = write_code;
    endcase
  end

  // Register file
  always_comb begin
    next_mode_reg_one = mode_reg_one;
    next_mode_reg_two = mode_reg_two;
    next_mode_reg_five = mode_reg_five;
    next_lat_cfg = lat_cfg;
    next_mode_cfg = mode_cfg;
    next_reg_rdata = 16'h0000;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `DTT_ADDR_MR1: next_mode_reg_one = reg_wdata_i;
        `DTT_ADDR_MR2: next_mode_reg_two = reg_wdata_i;
        `DTT_ADDR_MR5: next_mode_reg_five = reg_wdata_i;
        `DTT_ADDR_LAT: next_lat_cfg = {2'h0, reg_wdata_i[13:0]};
        `DTT_ADDR_MODE: next_mode_cfg = {6'h00, reg_wdata_i[9:0]};
        default: next_mode_cfg = mode_cfg;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `DTT_ADDR_MR1: next_reg_rdata = mode_reg_one;
        `DTT_ADDR_MR2: next_reg_rdata = mode_reg_two;
        `DTT_ADDR_MR5: next_reg_rdata = mode_reg_five;
        `DTT_ADDR_LAT: next_reg_rdata = lat_cfg;
        `DTT_ADDR_MODE: next_reg_rdata = mode_cfg;
        `DTT_ADDR_STAT: next_reg_rdata = {9'h000, wr_win, rd_win,
                                          rtt_code_o, rtt_kind_o};
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_reg_one <= `DTT_RST_MR;
      mode_reg_two <= `DTT_RST_MR;
      mode_reg_five <= `DTT_RST_MR;
      lat_cfg <= `DTT_RST_LAT;
      mode_cfg <= `DTT_RST_MODE;
      reg_rdata_o <= 16'h0000;
      rtt_kind_o <= dtt_pkg::DTT_HIZ;
      rtt_code_o <= 3'h0;
    end else begin
      mode_reg_one <= next_mode_reg_one;
      mode_reg_two <= next_mode_reg_two;
      mode_reg_five <= next_mode_reg_five;
      lat_cfg <= next_lat_cfg;
      mode_cfg <= next_mode_cfg;
      reg_rdata_o <= next_reg_rdata;
      rtt_kind_o <= next_rtt_kind;
      rtt_code_o <= next_rtt_code;
    end
  end

  // Helper counts of registered pin level, cleared by config writes
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic [7:0] next_hi_cnt;
  logic [7:0] next_lo_cnt;

  always_comb begin
    next_hi_cnt = 8'h00;
    next_lo_cnt = 8'h00;
    if (!reg_wr_i && die_termination_pin_i) begin
      next_hi_cnt = (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
    end
    if (!reg_wr_i && !die_termination_pin_i) begin
      next_lo_cnt = (lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end

  AST_SYNC_ON: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R2
    (dll_on && nominal_termination != 3'h0 && !rd_win && !wr_win &&
     hi_cnt >= {1'b0, direct_term_on_delay})
    |=> rtt_kind_o == dtt_pkg::DTT_NOM)
    else $error("nominal not on after direct latency");

  AST_SYNC_OFF: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R3
    (dll_on && !rd_win && !wr_win &&
     lo_cnt >= {1'b0, direct_term_on_delay})
    |=> rtt_kind_o != dtt_pkg::DTT_NOM)
    else $error("nominal not off after direct latency");

  AST_READ_HIZ: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R10
    (dll_on && hif[1].hist[read_term_off_delay - 7'h01])
    |=> rtt_kind_o == dtt_pkg::DTT_HIZ && rtt_code_o == 3'h0)
    else $error("termination on while read drives");

  AST_PARK_BACK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R6
    ($fell(rd_win) && !wr_win && !nom_req && park_code != 3'h0 &&
     !$past(reg_wr_i))
    |=> rtt_kind_o == dtt_pkg::DTT_PARK)
    else $error("park not restored after read");

  AST_WRITE_ON: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R14
    (dll_on && dyn_en && !rd_win &&
     hif[3].hist[write_strength_on_delay - 7'h01])
    |=> rtt_kind_o == dtt_pkg::DTT_WRITE && rtt_code_o == $past(write_code))
    else $error("write strength not selected");

  AST_WRITE_REL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R22
    ($fell(wr_win) && !rd_win && nom_req)
    |=> rtt_kind_o == dtt_pkg::DTT_NOM)
    else $error("write strength not released to nominal");

  AST_DLL_OFF_NO_WR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R17
    (!dll_on)[*2] |-> rtt_kind_o != dtt_pkg::DTT_WRITE)
    else $error("write strength with loop off");

  AST_ASYNC_NOM: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R19
    (!dll_on && die_termination_pin_i && nominal_termination != 3'h0 &&
     !reg_wr_i)[*2]
    |=> rtt_kind_o == dtt_pkg::DTT_NOM)
    else $error("async nominal late");

  AST_ASYNC_PARK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R20
    (!dll_on && !die_termination_pin_i && park_code != 3'h0 &&
     !reg_wr_i)[*2]
    |=> rtt_kind_o == dtt_pkg::DTT_PARK)
    else $error("async park late");

  AST_DYN_CODE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R11
    rtt_kind_o == dtt_pkg::DTT_WRITE |-> $past(dyn_en) && rtt_code_o != 3'h0)
    else $error("write strength without dynamic enable");

  AST_NOM_CODE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R12
    rtt_kind_o == dtt_pkg::DTT_NOM |-> rtt_code_o == $past(nominal_termination))
    else $error("nominal code mismatch");

  COV_WRITE: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rtt_kind_o == dtt_pkg::DTT_NOM ##1 rtt_kind_o == dtt_pkg::DTT_WRITE);
  COV_READ: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rtt_kind_o == dtt_pkg::DTT_HIZ ##1 rtt_kind_o == dtt_pkg::DTT_PARK);
  COV_ASYNC: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !dll_on && rtt_kind_o == dtt_pkg::DTT_NOM);
endmodule // dtt_ctrl

//--- core/dtt_defs.svh
// Offsets, field positions, reset values and latency offsets
// Assumes inclusion by bare name from the termination control files
`ifndef DTT_DEFS_SVH
`define DTT_DEFS_SVH

`define DTT_ADDR_MR1 3'h0
`define DTT_ADDR_MR2 3'h1
`define DTT_ADDR_MR5 3'h2
`define DTT_ADDR_LAT 3'h3
`define DTT_ADDR_MODE 3'h4
`define DTT_ADDR_STAT 3'h5

`define DTT_NOM_HI 10
`define DTT_NOM_LO 8
`define DTT_WR_HI 11
`define DTT_WR_LO 9
`define DTT_DYN_A9 9
`define DTT_DYN_A10 10
`define DTT_PARK_HI 8
`define DTT_PARK_LO 6

`define DTT_CWL_HI 4
`define DTT_CWL_LO 0
`define DTT_AL_HI 9
`define DTT_AL_LO 5
`define DTT_PL_HI 13
`define DTT_PL_LO 10
`define DTT_CL_HI 4
`define DTT_CL_LO 0
`define DTT_PRE2 5
`define DTT_CRC 6
`define DTT_BURST_HI 8
`define DTT_BURST_LO 7
`define DTT_DLL 9

`define DTT_RST_MR 16'h0000
`define DTT_RST_LAT 16'h0009
`define DTT_RST_MODE 16'h020b

`define DTT_MIN_LAT 8'h01
`define DTT_SUB_PRE1 8'h02
`define DTT_SUB_PRE2 8'h03
`define DTT_RD_CHOP_PRE1 7'h04
`define DTT_RD_CHOP_PRE2 7'h05
`define DTT_RD_FULL_PRE1 7'h06
`define DTT_RD_FULL_PRE2 7'h07
`define DTT_WC_PRE1 7'h04
`define DTT_WC_PRE1_CRC 7'h07
`define DTT_WC_PRE2 7'h05
`define DTT_WC_PRE2_CRC 7'h08
`define DTT_WF_PRE1 7'h06
`define DTT_WF_PRE1_CRC 7'h07
`define DTT_WF_PRE2 7'h07
`define DTT_WF_PRE2_CRC 7'h08

`endif

//--- core/dtt_pkg.sv
// Types of the termination timing control
// Assumes nothing beyond a SystemVerilog compiler
package dtt_pkg;
  typedef enum logic [1:0] {
    DTT_HIZ = 2'h0,
    DTT_PARK = 2'h1,
    DTT_NOM = 2'h3,
    DTT_WRITE = 2'h2
  } dtt_kind_t;
  typedef enum logic [1:0] {
    DTT_BL8_FIXED = 2'h0,
    DTT_BURST_OTF = 2'h1,
    DTT_BC4_FIXED = 2'h2,
    DTT_BURST_RSVD = 2'h3
  } dtt_burst_t;
endpackage

//--- core/dtt_hist_if.sv
// Carrier between the controller and its history lines
// Assumes one sample bit in and one history vector back
interface dtt_hist_if #(parameter int DEPTH = 128);
  logic sample;
  logic [DEPTH-1:0] hist;
  modport src(output sample, input hist);
  modport line(input sample, output hist);
endinterface

//--- core/dtt_hist.sv
// History line: one shift stage per clock for latency lookup
// Assumes the sample is synchronous to ref_clk_i
module dtt_hist #(
  parameter int DEPTH = 128
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  dtt_hist_if.line lp
);
  logic [DEPTH-1:0] next_hist;

  always_comb begin
    next_hist = {lp.hist[DEPTH-2:0], lp.sample};
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lp.hist <= '0;
    end else begin
      lp.hist <= next_hist;
    end
  end
endmodule // dtt_hist

//--- dv/dtt_ctrl_model.sv
// Controller-side model: termination pin and read/write commands
// Assumes the bench calls its tasks; drives just after ref_clk_i rises
module dtt_ctrl_model (
  input wire logic ref_clk_i,
  input wire logic [3:0] hold_i,
  output logic pin_o,
  output logic wr_o,
  output logic rd_o,
  output logic chop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int hi_cnt = 0;

  initial begin
    pin_o = 1'b0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    chop_o = 1'b0;
  end

  // Hold counted from first high or from a write
  always @(posedge ref_clk_i) begin
    hi_cnt <= !pin_o ? 0 : (wr_o ? 1 : hi_cnt + 1);
  end

  // Returns on the edge that registers the new level
  task automatic drive_pin(input logic v);
    if (!v) begin
      // Bench sets hold_i long enough for CRC and long preamble
      while (hi_cnt < int'(hold_i)) @(posedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    pin_o <= v;
    @(posedge ref_clk_i);
  endtask

  // One-cycle command; returns on the registering edge
  task automatic pulse(input logic wr, input logic rd, input logic ch);
    @(posedge ref_clk_i);
    wr_o <= wr;
    rd_o <= rd;
    chop_o <= ch;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    chop_o <= 1'b0;
  endtask
endmodule // dtt_ctrl_model

//--- dv/dtt_ctrl_tb_top.sv
// Self-checking bench for the termination timing control
// Assumes dtt_ctrl, its history lines and the controller model
module dtt_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic pin;
  logic cwr;
  logic crd;
  logic chop;
  dtt_pkg::dtt_kind_t kind;
  logic [2:0] code;
  int errors;
  int n_tests;
  int cnt;

  dtt_ctrl u_dtt_ctrl (
    .ref_clk_i(clk), .sys_rst_i(rst), .die_termination_pin_i(pin),
    .cmd_write_i(cwr), .cmd_read_i(crd), .cmd_chop_i(chop),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rtt_kind_o(kind),
    .rtt_code_o(code)
  );

  // Hold of 8 covers every burst, preamble and CRC case
  dtt_ctrl_model u_dtt_ctrl_model (
    .ref_clk_i(clk), .hold_i(4'h8), .pin_o(pin), .wr_o(cwr),
    .rd_o(crd), .chop_o(chop)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands one cycle only, then falls to zero
  task automatic reg_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
    #1 chk(rdata, 16'h0000);
  endtask

  task automatic step();
    @(posedge clk);
    #1 cnt++;
  endtask

  task automatic pin_to(input logic v);
    u_dtt_ctrl_model.drive_pin(v);
    cnt = 0;
  endtask

  task automatic cmd(input logic w, input logic r, input logic c);
    u_dtt_ctrl_model.pulse(w, r, c);
    cnt = 0;
  endtask

  // Cycles counted from the registering edge of pin or command
  task automatic wait_kind(input logic [1:0] k, input logic [2:0] c,
                           input int at);
    while (kind !== k && cnt < 300) step();
    chk(16'(cnt), 16'(at));
    chk({11'h0, kind, code}, {11'h0, k, c});
  endtask

  task automatic stay(input logic [1:0] k, input logic [2:0] c, input int n);
    repeat (n) begin
      step();
      chk({11'h0, kind, code}, {11'h0, k, c});
    end
  endtask

  task automatic t_regs();
    chk({11'h0, kind, code}, 16'h0000);
    reg_chk(3'h3, 16'h0009);
    reg_chk(3'h4, 16'h020b);
    reg_chk(3'h0, 16'h0000);
    reg_wr(3'h7, 16'hffff);
    reg_chk(3'h7, 16'h0000);
    reg_wr(3'h3, 16'hc009);
    reg_chk(3'h3, 16'h0009);
  endtask

  task automatic t_direct();
    reg_wr(3'h0, 16'h0500);
    reg_wr(3'h2, 16'h0080);
    for (int p = 0; p < 2; p++) begin
      reg_wr(3'h4, (p != 0) ? 16'h022b : 16'h020b);
      pin_to(1'b1);
      wait_kind(2'h3, 3'h5, 7 - p);
      pin_to(1'b0);
      wait_kind(2'h1, 3'h2, 7 - p);
    end
    reg_chk(3'h5, 16'h0009);
  endtask

  task automatic t_read();
    // Last entry: reserved burst code behaves as on-the-fly
    logic [15:0] md [6] = '{16'h020b, 16'h022b, 16'h030b, 16'h032b,
                            16'h028b, 16'h038b};
    int off [6] = '{9, 8, 9, 8, 9, 9};
    int on [6] = '{15, 15, 13, 13, 15, 15};
    for (int i = 0; i < 6; i++) begin
      reg_wr(3'h4, md[i]);
      cmd(1'b0, 1'b1, 1'b0);
      wait_kind(2'h0, 3'h0, off[i]);
      wait_kind(2'h1, 3'h2, on[i]);
    end
    reg_wr(3'h4, 16'h020b);
    pin_to(1'b1);
    wait_kind(2'h3, 3'h5, 7);
    cmd(1'b0, 1'b1, 1'b0);
    wait_kind(2'h0, 3'h0, 9);
    wait_kind(2'h3, 3'h5, 15);
    pin_to(1'b0);
    wait_kind(2'h1, 3'h2, 7);
  endtask

  task automatic t_dyn();
    int offs [8] = '{6, 7, 7, 8, 4, 5, 7, 8};
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'((i % 3) + 1);
      reg_wr(3'h1, {4'h0, c, 9'h000});
      reg_wr(3'h4, 16'h028b | 16'(i[0]) << 5 | 16'(i[1]) << 6);
      cmd(1'b1, 1'b0, i[2]);
      wait_kind(2'h2, c, 7 - i[0]);
      wait_kind(2'h1, 3'h2, 7 - i[0] + offs[i]);
    end
    reg_wr(3'h1, 16'h0400);
    reg_wr(3'h4, 16'h020b);
    pin_to(1'b1);
    wait_kind(2'h3, 3'h5, 7);
    cmd(1'b1, 1'b0, 1'b0);
    wait_kind(2'h2, 3'h2, 7);
    wait_kind(2'h3, 3'h5, 13);
    pin_to(1'b0);
    wait_kind(2'h1, 3'h2, 7);
    reg_wr(3'h1, 16'h0000);
    cmd(1'b1, 1'b0, 1'b0);
    stay(2'h1, 3'h2, 20);
  endtask

  // Loop off: no write strength, read hi-z left out by design
  task automatic t_loop_off();
    reg_wr(3'h4, 16'h000b);
    reg_wr(3'h1, 16'h0400);
    pin_to(1'b1);
    wait_kind(2'h3, 3'h5, 1);
    cmd(1'b1, 1'b0, 1'b0);
    stay(2'h3, 3'h5, 20);
    pin_to(1'b0);
    wait_kind(2'h1, 3'h2, 1);
    cmd(1'b0, 1'b1, 1'b0);
    stay(2'h1, 3'h2, 20);
  endtask

  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    errors = 0;
    n_tests = 0;
    cnt = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_direct();
    t_read();
    t_dyn();
    t_loop_off();
    summarize();
  end

  // Run needs about 500 cycles; 1 ms is far beyond that
  initial begin
    #1ms;
    errors++;
    summarize();
  end
endmodule // dtt_ctrl_tb_top
